// >>> sram_defs.svh
// Offsets, field positions, reset values and widths of the burst SRAM block
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

`define SRAM_ADDR_W        16
`define SRAM_DATA_W        32
`define SRAM_LANES         4
`define SRAM_DEPTH         65536

`define REG_CTRL_OFFSET    12'h000
`define REG_STATUS_OFFSET  12'h004
`define REG_OFFSET_W       12

`define CTRL_ENABLE_BIT    0
`define CTRL_RESET_VALUE   32'h0000_0001

`define STATUS_LO_POS      0
`define STATUS_CYCLE_POS   2
`define STATUS_DRIVE_BIT   5
`define STATUS_ORDER_BIT   6

`define AHB_SIZE_WORD      3'h2

`endif

// >>> sram_pkg.sv
// Types shared by the burst SRAM command logic
`default_nettype none
package sram_pkg;

  // Cycle captured at a clock edge
  typedef enum logic [2:0] {
    cyc_deselect,
    cyc_read_begin,
    cyc_write_begin,
    cyc_read_next,
    cyc_write_next,
    cyc_read_hold,
    cyc_write_hold
  } cycle_type;

endpackage
`default_nettype wire

// >>> burst_addr_counter.sv
// Two-bit burst address counter with linear and interleaved order
`default_nettype none
`include "sram_defs.svh"
module burst_addr_counter (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       load,
  input  wire logic [1:0] start_lo,
  input  wire logic       step,
  input  wire logic       interleave,
  output logic      [1:0] cur_lo,
  output logic      [1:0] nxt_lo
);

  logic [1:0] start_r;
  logic [1:0] count_r;
  logic [1:0] count_nxt;

  // Low address bits for a start value and a beat count
  function automatic logic [1:0] beat_addr(input logic [1:0] start,
                                           input logic [1:0] count,
                                           input logic       ilv);
    if (ilv) begin
      beat_addr = start ^ count;
    end else begin
      beat_addr = start + count;
    end
  endfunction

  // The two-bit count wraps by itself, so the fifth beat repeats the first
  assign count_nxt = count_r + 2'h1;
  assign cur_lo    = beat_addr(start_r, count_r, interleave);
  assign nxt_lo    = beat_addr(start_r, count_nxt, interleave);

  // Load wins over step; a begin cycle never advances
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_r <= 2'h0;
      count_r <= 2'h0;
    end else if (load) begin
      start_r <= start_lo;
      count_r <= 2'h0;
    end else if (step) begin
      count_r <= count_nxt;
    end
  end

endmodule // burst_addr_counter
`default_nettype wire

// >>> sram_ahb_regs.sv
// AHB-Lite slave holding the control and status registers
`default_nettype none
`include "sram_defs.svh"
module sram_ahb_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [31:0] status_word,
  output logic             sram_enable
);

  logic [31:0] ctrl_r;
  logic [31:0] hrdata_r;
  logic        wr_pend_r;
  logic [`REG_OFFSET_W-1:0] wr_off_r;
  wire         take;
  wire  [`REG_OFFSET_W-1:0] off;
  wire  [31:0] rd_value;

  // Zero wait states; every transfer answers OKAY
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = hrdata_r;
  assign sram_enable = ctrl_r[`CTRL_ENABLE_BIT];

  assign take = hsel & htrans[1] & hready;
  assign off  = haddr[`REG_OFFSET_W-1:0];
  assign rd_value = (off == `REG_CTRL_OFFSET)   ? ctrl_r :
                    (off == `REG_STATUS_OFFSET) ? status_word : 32'h0000_0000;

  // Read data is latched at the address phase so it stands for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r  <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_off_r  <= '0;
    end else if (hready) begin
      hrdata_r  <= (take && !hwrite) ? rd_value : 32'h0000_0000;
      wr_pend_r <= take & hwrite & (hsize == `AHB_SIZE_WORD);
      wr_off_r  <= off;
    end
  end

  // Only the enable bit is writable; other bits read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `CTRL_RESET_VALUE;
    end else if (wr_pend_r && hready && wr_off_r == `REG_CTRL_OFFSET) begin
      ctrl_r <= {31'h0000_0000, hwdata[`CTRL_ENABLE_BIT]};
    end
  end

endmodule // sram_ahb_regs
`default_nettype wire

// >>> sync_burst_sram.sv
// Synchronous burst SRAM: cycle decode, byte lanes, burst address and data pipe
`default_nettype none
`include "sram_defs.svh"

// Overview of operation
// - Linear order adds beat count modulo four
// - Interleaved order XORs start with beat count
// - Counter wraps to start after four beats
// - Write when all-lane low or gated lane
// - Gated write touches only lanes enabled low
// - Reads drive all four lanes
// - Writes keep all lane drivers off
// - Deselect decode turns data outputs off
// - Processor strobe begins read; controller strobe either
// - Write begins only on controller strobe alone
// - Both strobes idle, step low: next address
// - Both strobes idle, step high: same address
// - Composite enable: high select one, low zero
// - Output enable gates drivers asynchronously, only reads
// - Order pin low linear, high interleaved
// - All-lane write writes every lane
// - Dummy reads advance counter like reads
// - Deselect turns drivers off one stage early
module sync_burst_sram (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // Register bus
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic      [31:0]             hrdata,
  // Memory bus, synchronous to hclk
  input  wire logic [`SRAM_ADDR_W-1:0] addr,
  input  wire logic                    chip_select_low_a,
  input  wire logic                    chip_select_high,
  input  wire logic                    chip_select_low_b,
  input  wire logic                    processor_addr_strobe_n,
  input  wire logic                    controller_addr_strobe_n,
  input  wire logic                    burst_step_n,
  input  wire logic                    all_lane_write_n,
  input  wire logic                    lane_write_gate_n,
  input  wire logic                    lane0_write_n,
  input  wire logic                    lane1_write_n,
  input  wire logic                    lane2_write_n,
  input  wire logic                    lane3_write_n,
  input  wire logic                    burst_order_select_n,
  // Asynchronous output enable
  input  wire logic                    output_enable_n,
  // Data pins split into in, out and per-lane enable
  input  wire logic [`SRAM_DATA_W-1:0] dq_in,
  output logic      [`SRAM_DATA_W-1:0] dq_out,
  output logic      [`SRAM_LANES-1:0]  dq_oe
);

  // Storage array; word per address, four byte lanes
  logic [`SRAM_DATA_W-1:0] mem [0:`SRAM_DEPTH-1];

  // Captured cycle and its address
  sram_pkg::cycle_type     cycle_r;
  sram_pkg::cycle_type     cycle_nxt;
  logic [`SRAM_ADDR_W-3:0] addr_hi_r;
  logic [`SRAM_ADDR_W-1:0] rd_addr_r;
  logic                    rd_pend_r;
  logic [`SRAM_DATA_W-1:0] dout_r;
  logic                    drive_r;
  logic                    order_ilv_r;

  wire                     sram_enable;
  wire                     chip_enabled;
  wire                     write_qual;
  wire                     any_lane_n;
  wire [`SRAM_LANES-1:0]   lane_n;
  wire [`SRAM_LANES-1:0]   lane_we;
  wire                     sel_off;
  wire                     strobe_p;
  wire                     strobe_c;
  wire                     is_deselect;
  wire                     is_begin_rd;
  wire                     is_begin_wr;
  wire                     is_begin;
  wire                     is_step;
  wire                     is_write;
  wire                     is_read;
  wire [1:0]               cur_lo;
  wire [1:0]               nxt_lo;
  wire [1:0]               acc_lo;
  wire [`SRAM_ADDR_W-3:0]  acc_hi;
  wire [`SRAM_ADDR_W-1:0]  acc_addr;
  wire                     cap_off;
  wire [31:0]              status_word;

  // Register slave; the enable bit can park the memory in deselect
  sram_ahb_regs u_regs (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hwdata      (hwdata),
    .hready      (hready),
    .hreadyout   (hreadyout),
    .hresp       (hresp),
    .hrdata      (hrdata),
    .status_word (status_word),
    .sram_enable (sram_enable)
  );

  // Enables and write qualifier
  assign chip_enabled = chip_select_high & ~chip_select_low_b;
  assign lane_n       = {lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n};
  assign any_lane_n   = ~&lane_n;
  assign write_qual   = ~all_lane_write_n | (~lane_write_gate_n & any_lane_n);

  // All-lane write overrides the gate and the individual lanes
  assign lane_we = !all_lane_write_n  ? {`SRAM_LANES{1'b1}} :
                   !lane_write_gate_n ? ~lane_n :
                   {`SRAM_LANES{1'b0}};

  // Strobe decode; deselect has priority over begin, begin over continue
  assign sel_off     = chip_select_low_a;
  assign strobe_p    = ~processor_addr_strobe_n;
  assign strobe_c    = ~controller_addr_strobe_n;
  assign is_deselect = ~sram_enable |
                       (sel_off & strobe_c) |
                       (~sel_off & ~chip_enabled & (strobe_p | strobe_c));
  assign is_begin_rd = ~is_deselect & ~sel_off & chip_enabled &
                       (strobe_p | (strobe_c & ~write_qual));
  assign is_begin_wr = ~is_deselect & ~sel_off & chip_enabled &
                       ~strobe_p & strobe_c & write_qual;
  assign is_begin    = is_begin_rd | is_begin_wr;
  // Remaining combinations keep the burst: both strobes idle, or off with no controller strobe
  assign is_step     = ~is_deselect & ~is_begin & ~burst_step_n;
  assign is_write    = is_begin_wr | (~is_deselect & ~is_begin & write_qual);
  assign is_read     = ~is_deselect & ~is_write;

  // Cycle type for status and the output stage
  always_comb begin
    cycle_nxt = sram_pkg::cyc_deselect;
    if (is_deselect) begin
      cycle_nxt = sram_pkg::cyc_deselect;
    end else if (is_begin_rd) begin
      cycle_nxt = sram_pkg::cyc_read_begin;
    end else if (is_begin_wr) begin
      cycle_nxt = sram_pkg::cyc_write_begin;
    end else if (is_step) begin
      cycle_nxt = write_qual ? sram_pkg::cyc_write_next : sram_pkg::cyc_read_next;
    end else begin
      cycle_nxt = write_qual ? sram_pkg::cyc_write_hold : sram_pkg::cyc_read_hold;
    end
  end

  // Burst counter advances on every continue beat with the step pin low, dummy reads included
  burst_addr_counter u_burst (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .load       (is_begin),
    .start_lo   (addr[1:0]),
    .step       (is_step),
    .interleave (order_ilv_r),
    .cur_lo     (cur_lo),
    .nxt_lo     (nxt_lo)
  );

  // Begin uses the pins; continue uses held upper bits and the counter
  assign acc_hi   = is_begin ? addr[`SRAM_ADDR_W-1:2] : addr_hi_r;
  assign acc_lo   = is_begin ? addr[1:0] :
                    is_step  ? nxt_lo    : cur_lo;
  assign acc_addr = {acc_hi, acc_lo};

  // Mode pin is static; registered so order changes apply on the next edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      order_ilv_r <= 1'b1;
    end else begin
      order_ilv_r <= burst_order_select_n;
    end
  end

  // Input stage: captured cycle, held upper address and pending read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycle_r   <= sram_pkg::cyc_deselect;
      addr_hi_r <= '0;
      rd_addr_r <= '0;
      rd_pend_r <= 1'b0;
    end else begin
      cycle_r   <= cycle_nxt;
      rd_pend_r <= is_read;
      rd_addr_r <= acc_addr;
      if (is_begin) begin
        addr_hi_r <= addr[`SRAM_ADDR_W-1:2];
      end
    end
  end

  // Write data is taken with its command; only enabled lanes change
  always_ff @(posedge hclk) begin
    if (is_write) begin
      for (int i = 0; i < `SRAM_LANES; i++) begin
        if (lane_we[i]) begin
          mem[acc_addr][i*8 +: 8] <= dq_in[i*8 +: 8];
        end
      end
    end
  end

  // Output register: read data one edge after its command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout_r  <= '0;
      drive_r <= 1'b0;
    end else begin
      drive_r <= rd_pend_r;
      if (rd_pend_r) begin
        dout_r <= mem[rd_addr_r];
      end
    end
  end

  // A newly captured deselect or write shuts drivers at once, a stage ahead of data
  assign cap_off = (cycle_r == sram_pkg::cyc_deselect) |
                   (cycle_r == sram_pkg::cyc_write_begin) |
                   (cycle_r == sram_pkg::cyc_write_next) |
                   (cycle_r == sram_pkg::cyc_write_hold);

  // Output enable is combinational so it can cut drivers at any time
  assign dq_oe  = {`SRAM_LANES{drive_r & ~cap_off & ~output_enable_n}};
  assign dq_out = dout_r;

  // Status: low burst bits, captured cycle, driver state, burst order
  assign status_word = {25'h000_0000,
                        order_ilv_r,
                        drive_r & ~cap_off,
                        cycle_r,
                        cur_lo};

endmodule // sync_burst_sram
`default_nettype wire

// >>> sram_cmd_checker.sv
// Assertions on the burst SRAM cycle decode and data drivers
`default_nettype none
module sram_cmd_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        chip_select_low_a,
  input wire logic        chip_select_high,
  input wire logic        chip_select_low_b,
  input wire logic        processor_addr_strobe_n,
  input wire logic        controller_addr_strobe_n,
  input wire logic        burst_step_n,
  input wire logic        all_lane_write_n,
  input wire logic        lane_write_gate_n,
  input wire logic        lane0_write_n,
  input wire logic        lane1_write_n,
  input wire logic        lane2_write_n,
  input wire logic        lane3_write_n,
  input wire logic        output_enable_n,
  input wire logic [31:0] dq_out,
  input wire logic [3:0]  dq_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic pend_r;
  logic ctl_en_r;
  // Shadow of the enable bit, so refused cycles are not taken for reads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r   <= 1'b0;
      ctl_en_r <= 1'b1;
    end else begin
      pend_r   <= hsel & htrans[1] & hready & hwrite & (haddr[11:0] == 12'h000) & (hsize == 3'h2);
      ctl_en_r <= pend_r ? hwdata[0] : ctl_en_r;
    end
  end
  // Cycle decode from the pins
  wire logic sa  = ~chip_select_low_a;
  wire logic ce  = chip_select_high & ~chip_select_low_b;
  wire logic ps  = ~processor_addr_strobe_n;
  wire logic cs  = ~controller_addr_strobe_n;
  wire logic lw  = ~(lane0_write_n & lane1_write_n & lane2_write_n & lane3_write_n);
  wire logic wq  = ~all_lane_write_n | (~lane_write_gate_n & lw);
  wire logic cnt = ~cs & (~ps | ~sa);
  wire logic rdc = ctl_en_r & ((sa & ce & (ps | (cs & ~wq))) | (cnt & ~wq));
  wire logic wrc = (sa & ce & ~ps & cs & wq) | (cnt & wq);
  wire logic hld = ctl_en_r & cnt & burst_step_n & ~wq;
  sequence s_two_reads;
    rdc ##1 (rdc & ~output_enable_n);
  endsequence
  sequence s_two_holds;
    hld ##1 hld;
  endsequence
  property p_read_drive;
    s_two_reads |=> output_enable_n | (dq_oe == 4'hf);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read lanes not driven");
  property p_proc_read;
    (ctl_en_r & sa & ce & ps & wq) ##1 (rdc & ~output_enable_n) |=> output_enable_n | (dq_oe == 4'hf);
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("strobe read not driven");
  property p_write_off;
    wrc |=> dq_oe == 4'h0;
  endproperty
  a_write_off: assert property (p_write_off) else $error("drivers on in write");
  property p_desel_off;
    sa == 1'b0 && cs |=> dq_oe == 4'h0;
  endproperty
  a_desel_off: assert property (p_desel_off) else $error("drivers on after deselect");
  property p_ce_off;
    sa && !ce && (ps || cs) |=> dq_oe == 4'h0;
  endproperty
  a_ce_off: assert property (p_ce_off) else $error("drivers on with enable false");
  property p_oe_off;
    output_enable_n |-> dq_oe == 4'h0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drivers on with enable high");
  property p_oe_cause;
    dq_oe != 4'h0 |-> $past(rdc);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drivers on without read");
  property p_hold;
    s_two_holds ##1 1'b1 |=> $stable(dq_out);
  endproperty
  a_hold: assert property (p_hold) else $error("suspend changed data");
endmodule // sram_cmd_checker
bind sync_burst_sram sram_cmd_checker sram_cmd_checker_inst (.*);
`default_nettype wire

// >>> bus_master_model.sv
// Far-side controller model driving the synchronous memory pins
`default_nettype none
module bus_master_model (
  input  wire logic        hclk,
  output logic      [15:0] addr,
  output logic             chip_select_low_a,
  output logic             chip_select_high,
  output logic             chip_select_low_b,
  output logic             processor_addr_strobe_n,
  output logic             controller_addr_strobe_n,
  output logic             burst_step_n,
  output logic             all_lane_write_n,
  output logic             lane_write_gate_n,
  output logic             lane0_write_n,
  output logic             lane1_write_n,
  output logic             lane2_write_n,
  output logic             lane3_write_n,
  input  wire logic [31:0] dq_out,
  input  wire logic [3:0]  dq_oe,
  output logic      [31:0] dq_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] last_r;
  logic [31:0] wdata;
  logic        wdrive;
  wire logic [31:0] dm = {{8{dq_oe[3]}}, {8{dq_oe[2]}}, {8{dq_oe[1]}}, {8{dq_oe[0]}}};
  // Lanes nobody drives show the inverse of the last level, never a stale copy
  assign dq_in = wdrive ? wdata : ((dq_out & dm) | (~last_r & ~dm));
  always @(posedge hclk) last_r <= dq_in;
  initial begin
    addr = 16'h0000;
    {chip_select_low_a, chip_select_high, chip_select_low_b} = 3'h6;
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n} = 3'h5;
    {all_lane_write_n, lane_write_gate_n, lane3_write_n, lane2_write_n} = 4'hf;
    {lane1_write_n, lane0_write_n} = 2'h3;
    wdrive = 1'b0;
    wdata = 32'h0;
  end
  // One cycle: pins change after an edge and are sampled at the next
  task automatic cyc(input logic [15:0] a, input logic [2:0] sel, input logic [2:0] str,
                     input logic [5:0] wr, input logic [31:0] d);
    @(posedge hclk);
    addr <= a;
    {chip_select_low_a, chip_select_high, chip_select_low_b} <= sel;
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n} <= str;
    {all_lane_write_n, lane_write_gate_n, lane3_write_n, lane2_write_n} <= wr[5:2];
    {lane1_write_n, lane0_write_n} <= wr[1:0];
    wdrive <= ~wr[5] | (~wr[4] & ~&wr[3:0]);
    wdata <= d;
  endtask
endmodule // bus_master_model
`default_nettype wire

// >>> sync_burst_sram_command_logic_bench.sv
// Self-checking bench of the burst SRAM command logic
`default_nettype none
module sync_burst_sram_command_logic_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] S_ON = 3'h2, S_OFF = 3'h6, B_C = 3'h5, HD = 3'h7;
  localparam logic [5:0] W_ALL = 6'h1f, RD = 6'h3f;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, output_enable_n, burst_order_select_n, v1, v2;
  logic [31:0] haddr, hwdata, ex1, ex2, rd;
  logic [31:0] mem [0:15];
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          errors, tests_run;
  wire logic        hreadyout, hresp, chip_select_low_a, chip_select_high, chip_select_low_b;
  wire logic        processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n;
  wire logic        all_lane_write_n, lane_write_gate_n, lane0_write_n, lane1_write_n;
  wire logic        lane2_write_n, lane3_write_n;
  wire logic [15:0] addr;
  wire logic [31:0] hrdata, dq_in, dq_out;
  wire logic [3:0]  dq_oe;
  wire logic        hready = hreadyout;
  sync_burst_sram sync_burst_sram_inst (.*);
  bus_master_model bus_master_model_inst (.*);
  // Half period of 2 ns
  always #2 hclk = ~hclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Single word transfer; zero-wait answers are still waited for, bounded
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 20'h0, a};
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin errors++; summarize; end
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin errors++; summarize; end
    check({30'h0, hresp, hreadyout}, 32'h1); // Zero waits and an OKAY answer
  endtask
  // Issue one memory cycle and judge the read data of the cycle two calls back
  task automatic go(input logic [15:0] a, input logic [2:0] sel, input logic [2:0] str,
                    input logic [5:0] wr, input logic [31:0] d, input logic v,
                    input logic [31:0] e);
    bus_master_model_inst.cyc(a, sel, str, wr, d);
    #1;
    if (v2) check(dq_out, ex2);
    {v2, ex2, v1, ex1} = {v1, ex1, v, e};
  endtask
  task automatic idle;
    repeat (2) go(16'h0, S_OFF, B_C, RD, 32'h0, 1'b0, 32'h0);
  endtask
  task automatic t_fill;
    for (int i = 0; i < 16; i++) begin
      mem[i] = 32'hc0de_0000 + 32'(i) * 32'h0001_0101;
      go(16'h1230 + 16'(i), S_ON, B_C, W_ALL, mem[i], 1'b0, 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      go(16'h1230 + 16'(k), S_ON, B_C, {2'h2, ~(4'h1 << k)}, 32'hffff_ffff, 1'b0, 32'h0);
      mem[k][8*k +: 8] = 8'hff;
    end
    go(16'h1234, S_ON, B_C, 6'h30, 32'h0, 1'b0, 32'h0);
    mem[5] = 32'h5a5a_5a5a;
    go(16'h1235, S_ON, B_C, 6'h10, mem[5], 1'b0, 32'h0);
    go(16'h1236, S_ON, 3'h3, W_ALL, 32'h0, 1'b0, 32'h0);
    for (int i = 0; i < 16; i++) go(16'h1230 + 16'(i), S_ON, B_C, RD, 32'h0, 1'b1, mem[i]);
    idle;
  endtask
  // Burst from a mid start, foreign upper address bits, three dummy beats, then suspend
  task automatic t_burst(input logic ord, input logic [1:0] st);
    logic [1:0] lo;
    @(posedge hclk);
    burst_order_select_n <= ord;
    go(16'h1230 + 16'(st), S_ON, B_C, RD, 32'h0, 1'b1, mem[st]);
    for (int k = 1; k < 6; k++) begin
      lo = ord ? st ^ 2'(k) : st + 2'(k);
      output_enable_n <= (k == 2);
      go(16'hffc0, k[0] ? S_OFF : S_ON, 3'(k[0] ? 2 : 6), RD, 32'h0, 1'b1, mem[lo]);
    end
    repeat (2) go(16'hffc0, S_ON, HD, RD, 32'h0, 1'b1, mem[lo]);
    idle;
  endtask
  // Driver state after enable mixes, a deselect and a write that follow reads
  task automatic t_drive;
    for (int i = 0; i < 6; i++) begin
      repeat (2) go(16'h1233, S_ON, B_C, RD, 32'h0, 1'b0, 32'h0);
      // Lanes low with the gate high is still a read on all four lanes
      go(16'h1231, i < 4 ? 3'(i) : (i == 4 ? S_OFF : S_ON), B_C, i == 5 ? W_ALL : 6'h30, mem[1],
         1'b0, 32'h0);
      // The command is captured at the next edge; drivers follow right after it
      @(posedge hclk);
      #1;
      check({28'h0, dq_oe}, i == 2 ? 32'hf : 32'h0);
      output_enable_n <= 1'b1;
      #1;
      check({28'h0, dq_oe}, 32'h0);
      output_enable_n <= 1'b0;
    end
    idle;
  endtask
  task automatic t_regs;
    ahb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h1); // Enable resets set
    ahb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0); // Unmapped place reads zero
    ahb(1'b0, 12'h004, 32'h0);
    check(rd & 32'hfc, {25'h0, burst_order_select_n, 6'h0});
    ahb(1'b1, 12'h000, 32'h0);
    go(16'h1235, S_ON, B_C, W_ALL, 32'h0bad_0bad, 1'b0, 32'h0);
    repeat (2) go(16'h1235, S_ON, B_C, RD, 32'h0, 1'b0, 32'h0);
    // Wait for the second read to be captured, when an enabled part would drive
    @(posedge hclk);
    #1;
    check({28'h0, dq_oe}, 32'h0); // Disabled part refuses reads
    ahb(1'b1, 12'h000, 32'h1);
    go(16'h1235, S_ON, B_C, RD, 32'h0, 1'b1, mem[5]); // Refused write left data
    idle;
  endtask
  initial begin
    {hresetn, hsel, hwrite, output_enable_n, burst_order_select_n} = 5'h01;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    {v1, v2, ex1, ex2} = 66'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_fill;
    $display("fill and byte lanes done");
    for (int o = 0; o < 2; o++) for (int s = 1; s < 4; s += 2) t_burst(1'(o), 2'(s));
    $display("burst orders done");
    t_drive;
    $display("driver control done");
    t_regs;
    $display("registers done");
    summarize;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    errors++;
    summarize;
  end
endmodule // sync_burst_sram_command_logic_bench
`default_nettype wire
